// file: hdl/ehs_pkg.sv
`default_nettype none
package ehs_pkg;

  // ***************************************************************
  // Sizes
  // ***************************************************************
  localparam int unsigned N_CH     = 8;
  localparam int unsigned N_KIND   = 7;
  localparam int unsigned N_SRC    = 59;
  localparam int unsigned SRC_W    = 6;
  localparam int unsigned HIST_MAX = 17;
  localparam int unsigned CNT_W    = 5;

  // ***************************************************************
  // Object indices and sub-indices
  // ***************************************************************
  localparam logic [15:0] IDX_DEV_TYPE   = 16'h1000;
  localparam logic [15:0] IDX_ERR_REG    = 16'h1001;
  localparam logic [15:0] IDX_MAKER_STAT = 16'h1002;
  localparam logic [15:0] IDX_ERR_HIST   = 16'h1003;
  localparam logic [7:0]  SUB_COUNT      = 8'h00;
  localparam logic [7:0]  SUB_LAST       = 8'h11;

  // ***************************************************************
  // Reset values and field positions
  // ***************************************************************
  localparam logic [7:0]  ERR_REG_RESET  = 8'h00;
  localparam int unsigned GEN_ERR_BIT    = 0;
  localparam logic [15:0] ADDL_ANALOG_IN = 16'h0002;

  // ***************************************************************
  // Emergency codes and fault descriptions
  // ***************************************************************
  localparam logic [15:0] EMCY_RESET    = 16'h0000;
  localparam logic [15:0] EMCY_OVERRUN  = 16'h8110;
  localparam logic [15:0] EMCY_GUARD    = 16'h8130;
  localparam logic [15:0] EMCY_INPUT    = 16'hF001;
  localparam logic [15:0] EMCY_LIMIT    = 16'hF011;
  localparam logic [15:0] EMCY_DEVICE   = 16'hFF00;
  localparam logic [15:0] MS_LIFEGUARD  = 16'h1000;
  localparam logic [7:0]  DESC_OPEN     = 8'h02;
  localparam logic [7:0]  DESC_SHORT    = 8'h04;
  localparam logic [7:0]  DESC_MATH     = 8'h08;
  localparam logic [7:0]  DESC_LOW      = 8'h10;
  localparam logic [7:0]  DESC_HIGH     = 8'h20;
  localparam logic [7:0]  DESC_SHUT     = 8'h40;
  localparam logic [7:0]  DESC_FROZEN   = 8'h80;
  localparam logic [7:0]  DESC_HB       = 8'h80;

  // Sources 0..55 are channel*7+kind; the rest are node-wide
  localparam logic [5:0]  SRC_GUARD     = 6'h38;
  localparam logic [5:0]  SRC_HB        = 6'h39;
  localparam logic [5:0]  SRC_OVR       = 6'h3A;

  typedef enum logic [2:0] {
    KIND_OPEN   = 3'h0,
    KIND_SHORT  = 3'h1,
    KIND_LOW    = 3'h2,
    KIND_HIGH   = 3'h3,
    KIND_SHUT   = 3'h4,
    KIND_MATH   = 3'h5,
    KIND_FROZEN = 3'h6
  } ehs_kind_e;

endpackage : ehs_pkg
`default_nettype wire

// file: hdl/ehs_fault_map.sv
`timescale 1ns/100ps
`default_nettype none
module ehs_fault_map (
  input  wire logic [5:0]  src_idx,
  input  wire logic [7:0]  hb_node,
  output logic      [31:0] entry_word
);

  // ***************************************************************
  // Source number to history entry
  // ***************************************************************
  always_comb begin
    logic [5:0]       ch;
    ehs_pkg::ehs_kind_e kd;
    logic [7:0]       chan;
    ch         = src_idx / 6'h07;
    kd         = ehs_pkg::ehs_kind_e'(3'(src_idx % 6'h07));
    chan       = {2'h0, ch} + 8'h01;  // RQ14
    entry_word = 32'h0000_0000;
    if (src_idx == ehs_pkg::SRC_GUARD) begin
      entry_word = {ehs_pkg::MS_LIFEGUARD, ehs_pkg::EMCY_GUARD};  // RQ9
    end else if (src_idx == ehs_pkg::SRC_HB) begin
      entry_word = {ehs_pkg::DESC_HB, hb_node, ehs_pkg::EMCY_GUARD};  // RQ10
    end else if (src_idx == ehs_pkg::SRC_OVR) begin
      entry_word = {16'h0000, ehs_pkg::EMCY_OVERRUN};  // RQ15
    end else begin
      case (kd)  // RQ8
        ehs_pkg::KIND_OPEN:   entry_word = {ehs_pkg::DESC_OPEN, chan, ehs_pkg::EMCY_INPUT};  // RQ11
        ehs_pkg::KIND_SHORT:  entry_word = {ehs_pkg::DESC_SHORT, chan, ehs_pkg::EMCY_INPUT};  // RQ11
        ehs_pkg::KIND_LOW:    entry_word = {ehs_pkg::DESC_LOW, chan, ehs_pkg::EMCY_LIMIT};  // RQ12
        ehs_pkg::KIND_HIGH:   entry_word = {ehs_pkg::DESC_HIGH, chan, ehs_pkg::EMCY_LIMIT};  // RQ12
        ehs_pkg::KIND_SHUT:   entry_word = {ehs_pkg::DESC_SHUT, chan, ehs_pkg::EMCY_LIMIT};  // RQ12
        ehs_pkg::KIND_MATH:   entry_word = {ehs_pkg::DESC_MATH, chan, ehs_pkg::EMCY_DEVICE};  // RQ13
        ehs_pkg::KIND_FROZEN: entry_word = {ehs_pkg::DESC_FROZEN, chan, ehs_pkg::EMCY_DEVICE};  // RQ13
        default:              entry_word = 32'h0000_0000;
      endcase
    end
  end

endmodule : ehs_fault_map
`default_nettype wire

// file: hdl/ehs_core.sv
// Function
// RQ1: Any active error sets generic error bit.
// RQ2: Bit clears when no error; others zero.
// RQ3: New error inserted on top; removed on clear.
// RQ4: Newest at sub-index 1; sub 0 counts.
// RQ5: Writing zero to count empties list.
// RQ6: Emptying list leaves error bit alone.
// RQ7: At most seventeen entries; oldest dropped.
// RQ8: Entry: description, channel, emergency code.
// RQ9: Life guard timeout logs 0x1000, 0x8130.
// RQ10: Heartbeat miss logs 0x80, node, 0x8130.
// RQ11: Open/short circuit: 0xF001, 0x02/0x04.
// RQ12: Thresholds: 0xF011, 0x10/0x20/0x40.
// RQ13: Scanner faults: 0xFF00, 0x08/0x80.
// RQ14: Channel byte is input number 1..8.
// RQ15: Codes 0x0000 reset and 0x8110 overrun.
// RQ16: Device type halves; analog input flag.
// RQ17: Master invalidates PDO before remap, revalidates.
// RQ18: Master zeroes mapping count, edits, restores.
// RQ19: Middle removal closes gap, count drops.
`timescale 1ns/100ps
`default_nettype none
module ehs_core #(
  parameter logic [15:0] DT_GEN  = 16'h0ABC,  // Arbitrary profile value
  parameter logic [15:0] DT_ADDL = 16'h2002   // Arbitrary; bit 1 marks analog input
) (
  input  wire logic        clk_sys,
  input  wire logic        reset,
  input  wire logic        ce,
  input  wire logic [7:0]  flt_open,
  input  wire logic [7:0]  flt_short,
  input  wire logic [7:0]  thr_low,
  input  wire logic [7:0]  thr_high,
  input  wire logic [7:0]  thr_shut,
  input  wire logic [7:0]  calc_err,
  input  wire logic [7:0]  adc_frozen,
  input  wire logic        guard_timeout,
  input  wire logic        hb_missing,
  input  wire logic [7:0]  hb_node,
  input  wire logic        can_overrun,
  input  wire logic        od_req,
  input  wire logic        od_write,
  input  wire logic [15:0] od_index,
  input  wire logic [7:0]  od_subindex,
  input  wire logic [31:0] od_wdata,
  output logic             od_ack_q,
  output logic             od_abort_q,
  output logic      [31:0] od_rdata_q,
  output logic      [7:0]  err_reg_q,
  output logic             emcy_strobe_q,
  output logic      [31:0] emcy_word_q
);

  localparam int unsigned NS = ehs_pkg::N_SRC;
  localparam int unsigned HM = ehs_pkg::HIST_MAX;

  // ***************************************************************
  // Helpers
  // ***************************************************************
  function automatic logic [6:0] pick_first(input logic [NS-1:0] v);
    logic [6:0] r;
    r = 7'h00;
    for (int i = NS - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = {1'b1, 6'(i)};
      end
    end
    return r;
  endfunction : pick_first

  // ***************************************************************
  // Error conditions
  // ***************************************************************
  logic [NS-1:0] cond;
  logic          any_err;

  always_comb begin
    cond = '0;
    for (int c = 0; c < ehs_pkg::N_CH; c++) begin
      cond[c*7+0] = flt_open[c];
      cond[c*7+1] = flt_short[c];
      cond[c*7+2] = thr_low[c];
      cond[c*7+3] = thr_high[c];
      cond[c*7+4] = thr_shut[c];
      cond[c*7+5] = calc_err[c];
      cond[c*7+6] = adc_frozen[c];
    end
    cond[ehs_pkg::SRC_GUARD] = guard_timeout;
    cond[ehs_pkg::SRC_HB]    = hb_missing;
    cond[ehs_pkg::SRC_OVR]   = can_overrun;
    any_err = |cond;
  end

  // ***************************************************************
  // History list state
  // ***************************************************************
  logic [31:0]              ent_q [HM];
  logic [31:0]              ent_d [HM];
  logic [5:0]               src_q [HM];
  logic [5:0]               src_d [HM];
  logic [ehs_pkg::CNT_W-1:0] cnt_q, cnt_d;
  logic [NS-1:0]            seen_q, seen_d;
  logic                     emcy_strobe_d;
  logic [31:0]              emcy_word_d;
  logic                     list_clr;
  logic [6:0]               fall_pick, rise_pick;
  logic [31:0]              new_word;
  logic                     do_rem, do_ins;

  // A condition is handled once: a fall removes, a rise inserts, one per cycle
  assign fall_pick = pick_first(seen_q & ~cond);
  assign rise_pick = pick_first(cond & ~seen_q);
  // A clear stalls event handling for a cycle rather than dropping the event
  assign do_rem    = !list_clr && fall_pick[6];
  assign do_ins    = !list_clr && !fall_pick[6] && rise_pick[6];

  ehs_fault_map u_map (
    .src_idx    (rise_pick[5:0]),
    .hb_node    (hb_node),
    .entry_word (new_word)
  );

  always_comb begin
    logic                     hit;
    logic [ehs_pkg::CNT_W-1:0] pos;
    hit           = 1'b0;
    pos           = '0;
    ent_d         = ent_q;
    src_d         = src_q;
    cnt_d         = cnt_q;
    seen_d        = seen_q;
    emcy_strobe_d = 1'b0;
    emcy_word_d   = emcy_word_q;
    for (int i = 0; i < HM; i++) begin
      if (!hit && (5'(i) < cnt_q) && (src_q[i] == fall_pick[5:0])) begin
        hit = 1'b1;
        pos = 5'(i);
      end
    end
    if (list_clr) begin
      cnt_d = '0;  // RQ5
      for (int i = 0; i < HM; i++) begin
        ent_d[i] = 32'h0000_0000;
      end
    end else if (do_rem) begin
      seen_d[fall_pick[5:0]] = 1'b0;  // RQ3
      if (hit) begin
        for (int i = 0; i < HM - 1; i++) begin
          if (5'(i) >= pos) begin
            ent_d[i] = ent_q[i+1];  // RQ19
            src_d[i] = src_q[i+1];
          end
        end
        ent_d[HM-1] = 32'h0000_0000;
        cnt_d       = cnt_q - 5'h01;  // RQ19
      end
      if (seen_d == '0) begin
        emcy_strobe_d = 1'b1;
        emcy_word_d   = {16'h0000, ehs_pkg::EMCY_RESET};  // RQ15
      end
    end else if (do_ins) begin
      seen_d[rise_pick[5:0]] = 1'b1;
      for (int i = HM - 1; i > 0; i--) begin
        ent_d[i] = ent_q[i-1];  // RQ7
        src_d[i] = src_q[i-1];
      end
      ent_d[0]      = new_word;  // RQ3 RQ4
      src_d[0]      = rise_pick[5:0];
      cnt_d         = (cnt_q == 5'(HM)) ? cnt_q : cnt_q + 5'h01;  // RQ7
      emcy_strobe_d = 1'b1;
      emcy_word_d   = new_word;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < HM; i++) begin
        ent_q[i] <= 32'h0000_0000;
        src_q[i] <= 6'h00;
      end
      cnt_q         <= '0;
      seen_q        <= '0;
      emcy_strobe_q <= 1'b0;
      emcy_word_q   <= 32'h0000_0000;
    end else if (ce) begin
      ent_q         <= ent_d;
      src_q         <= src_d;
      cnt_q         <= cnt_d;
      seen_q        <= seen_d;
      emcy_strobe_q <= emcy_strobe_d;
      emcy_word_q   <= emcy_word_d;
    end
  end

  // ***************************************************************
  // Object access
  // ***************************************************************
  logic        od_ack_d, od_abort_d;
  logic [31:0] od_rdata_d;
  logic [7:0]  err_reg_d;

  always_comb begin
    logic [4:0] sel;
    sel        = 5'(od_subindex - 8'h01);
    od_ack_d   = od_req;
    od_abort_d = 1'b0;
    od_rdata_d = 32'h0000_0000;
    list_clr   = 1'b0;
    // Tracks live conditions, so a list clear never hides an active fault
    err_reg_d  = ehs_pkg::ERR_REG_RESET;  // RQ2
    err_reg_d[ehs_pkg::GEN_ERR_BIT] = any_err;  // RQ1 RQ6
    if (od_req) begin
      case (od_index)
        ehs_pkg::IDX_DEV_TYPE: begin
          if (od_write || od_subindex != 8'h00) begin
            od_abort_d = 1'b1;
          end else begin
            od_rdata_d = {DT_ADDL | ehs_pkg::ADDL_ANALOG_IN, DT_GEN};  // RQ16
          end
        end
        ehs_pkg::IDX_ERR_REG: begin
          if (od_write || od_subindex != 8'h00) begin
            od_abort_d = 1'b1;
          end else begin
            od_rdata_d = {24'h00_0000, err_reg_q};  // RQ2
          end
        end
        ehs_pkg::IDX_MAKER_STAT: begin
          if (od_write || od_subindex != 8'h00) begin
            od_abort_d = 1'b1;
          end else begin
            od_rdata_d = {25'h000_0000, fall_pick[6], rise_pick[6], cnt_q};
          end
        end
        ehs_pkg::IDX_ERR_HIST: begin
          if (od_subindex == ehs_pkg::SUB_COUNT) begin
            if (od_write) begin
              // Only zero is a legal count write
              list_clr   = (od_wdata == 32'h0000_0000);  // RQ5
              od_abort_d = !list_clr;
            end else begin
              od_rdata_d = {27'h000_0000, cnt_q};  // RQ4
            end
          end else if (od_subindex <= ehs_pkg::SUB_LAST && !od_write) begin
            od_rdata_d = (sel < cnt_q) ? ent_q[sel] : 32'h0000_0000;  // RQ4
          end else begin
            od_abort_d = 1'b1;
          end
        end
        default: od_abort_d = 1'b1;
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      od_ack_q   <= 1'b0;
      od_abort_q <= 1'b0;
      od_rdata_q <= 32'h0000_0000;
      err_reg_q  <= ehs_pkg::ERR_REG_RESET;
    end else if (ce) begin
      od_ack_q   <= od_ack_d;
      od_abort_q <= od_abort_d;
      od_rdata_q <= od_rdata_d;
      err_reg_q  <= err_reg_d;
    end
  end

  // ***************************************************************
  // Assertions
  // ***************************************************************
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);

  property p_err_set;
    ce && any_err |=> err_reg_q == 8'h01;
  endproperty
  a_err_set: assert property (p_err_set) else $error("error bit not set"); // RQ1

  property p_err_clear;
    ce && !any_err |=> err_reg_q == 8'h00;
  endproperty
  a_err_clear: assert property (p_err_clear) else $error("error bit not cleared"); // RQ2

  property p_insert_top;
    logic [31:0] w;
    (ce && do_ins, w = new_word) |=> ent_q[0] == w && emcy_strobe_q && emcy_word_q == w;
  endproperty
  a_insert_top: assert property (p_insert_top) else $error("new entry not on top"); // RQ3

  property p_count_read;
    ce && od_req && !od_write && od_index == 16'h1003 && od_subindex == 8'h00
      |=> od_ack_q && od_rdata_q == {27'h000_0000, $past(cnt_q)};
  endproperty
  a_count_read: assert property (p_count_read) else $error("count read wrong"); // RQ4

  property p_clear;
    ce && list_clr |=> cnt_q == 5'h00 ##1 (cnt_q <= 5'h01);
  endproperty
  a_clear: assert property (p_clear) else $error("list not emptied"); // RQ5

  property p_clear_keeps_flag;
    ce && list_clr && any_err |=> err_reg_q[0];
  endproperty
  a_clear_keeps_flag: assert property (p_clear_keeps_flag) else $error("flag lost"); // RQ6

  property p_max;
    cnt_q <= 5'h11;
  endproperty
  a_max: assert property (p_max) else $error("history overflow"); // RQ7

  property p_guard_word;
    do_ins && rise_pick[5:0] == 6'h38 |-> new_word == 32'h1000_8130;
  endproperty
  a_guard_word: assert property (p_guard_word) else $error("guard entry wrong"); // RQ9

  property p_open_word;
    do_ins && rise_pick[5:0] == 6'h00 |-> new_word == 32'h0201_F001;
  endproperty
  a_open_word: assert property (p_open_word) else $error("open entry wrong"); // RQ11

  property p_devtype;
    ce && od_req && !od_write && od_index == 16'h1000 && od_subindex == 8'h00
      |=> od_rdata_q[17] && od_rdata_q[15:0] == DT_GEN;
  endproperty
  a_devtype: assert property (p_devtype) else $error("device type wrong"); // RQ16

  property p_remove;
    ce && do_rem && cnt_q != 5'h00 && fall_pick[5:0] == src_q[0]
      |=> cnt_q == $past(cnt_q) - 5'h01;
  endproperty
  a_remove: assert property (p_remove) else $error("removal count wrong"); // RQ19

  c_full: cover property (ce && do_ins && cnt_q == 5'h11);
  c_clear_active: cover property (ce && list_clr && any_err);
  c_mid_remove: cover property (ce && do_rem && cnt_q > 5'h02);
  c_reset_code: cover property (emcy_strobe_q && emcy_word_q == 32'h0000_0000);

endmodule : ehs_core
`default_nettype wire

// file: verif/ehs_sdo_master.sv
`timescale 1ns/100ps
`default_nettype none
// ***************************************************************
// Object access master
// ***************************************************************
module ehs_sdo_master (
  input  wire logic        clk_sys,
  output logic             od_req,
  output logic             od_write,
  output logic      [15:0] od_index,
  output logic      [7:0]  od_subindex,
  output logic      [31:0] od_wdata
);
  initial begin
    od_req      = 1'b0;
    od_write    = 1'b0;
    od_index    = 16'h0000;
    od_subindex = 8'h00;
    od_wdata    = 32'h0;
  end

  // Each high cycle of the request is one access, so it drops on the edge that takes it
  task automatic xfer(input logic w, input logic [15:0] ix, input logic [7:0] sb,
                      input logic [31:0] wd);
    @(posedge clk_sys);
    od_req      <= 1'b1;
    od_write    <= w;
    od_index    <= ix;
    od_subindex <= sb;
    od_wdata    <= wd;
    @(posedge clk_sys);
    od_req      <= 1'b0;
    // Released qualifiers carry garbage so a late sample cannot pass
    od_write    <= ~w;
    od_index    <= ~ix;
    od_subindex <= ~sb;
    od_wdata    <= ~wd;
  endtask : xfer
endmodule : ehs_sdo_master
`default_nettype wire

// file: verif/ehs_core_tb.sv
`timescale 1ns/100ps
`default_nettype none
module ehs_core_tb;
  localparam logic [15:0] DTG = 16'h0123;  // Arbitrary profile value
  localparam logic [15:0] DTA = 16'h7002;  // Arbitrary; analog input flag set
  localparam logic [7:0]  DSC [7] = '{ehs_pkg::DESC_OPEN, ehs_pkg::DESC_SHORT,
    ehs_pkg::DESC_LOW, ehs_pkg::DESC_HIGH, ehs_pkg::DESC_SHUT, ehs_pkg::DESC_MATH,
    ehs_pkg::DESC_FROZEN};
  logic        clk_sys, reset, ce, guard, hbm, ovr;
  logic [7:0]  fk [7];
  logic [7:0]  hbn, err_reg_q;
  logic        od_req, od_write, od_ack_q, od_abort_q, emcy_strobe_q;
  logic [15:0] od_index;
  logic [7:0]  od_subindex;
  logic [31:0] od_wdata, od_rdata_q, emcy_word_q, seed, w;
  logic [32:0] qa [$];
  logic [31:0] qe [$];
  int          errors, check_count, c;

  ehs_core #(.DT_GEN(DTG), .DT_ADDL(DTA)) i_dut (
    .clk_sys(clk_sys), .reset(reset), .ce(ce),
    .flt_open(fk[0]), .flt_short(fk[1]), .thr_low(fk[2]), .thr_high(fk[3]),
    .thr_shut(fk[4]), .calc_err(fk[5]), .adc_frozen(fk[6]),
    .guard_timeout(guard), .hb_missing(hbm), .hb_node(hbn), .can_overrun(ovr),
    .od_req(od_req), .od_write(od_write), .od_index(od_index),
    .od_subindex(od_subindex), .od_wdata(od_wdata), .od_ack_q(od_ack_q),
    .od_abort_q(od_abort_q), .od_rdata_q(od_rdata_q), .err_reg_q(err_reg_q),
    .emcy_strobe_q(emcy_strobe_q), .emcy_word_q(emcy_word_q));

  ehs_sdo_master i_mst (
    .clk_sys(clk_sys), .od_req(od_req), .od_write(od_write), .od_index(od_index),
    .od_subindex(od_subindex), .od_wdata(od_wdata));

  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  // ***************************************************************
  // Helpers
  // ***************************************************************
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  // Sources 0..6 are per-input kinds, 7 guard, 8 heartbeat, 9 overrun
  function automatic logic [31:0] wrd(input int k, input int ch);
    logic [15:0] code;
    code = (k < 2) ? ehs_pkg::EMCY_INPUT : (k < 5) ? ehs_pkg::EMCY_LIMIT : ehs_pkg::EMCY_DEVICE;
    if (k == 7) return {ehs_pkg::MS_LIFEGUARD, ehs_pkg::EMCY_GUARD};
    if (k == 8) return {ehs_pkg::DESC_HB, hbn, ehs_pkg::EMCY_GUARD};
    if (k == 9) return {16'h0000, ehs_pkg::EMCY_OVERRUN};
    return {DSC[k], 8'(ch + 1), code};
  endfunction : wrd

  task automatic set_src(input int k, input int ch, input logic v);
    if (k < 7) fk[k][ch] <= v;
    else if (k == 7) guard <= v;
    else if (k == 8) hbm <= v;
    else ovr <= v;
  endtask : set_src

  task automatic acc(input logic wr, input logic [15:0] ix, input logic [7:0] sb,
                     input logic [31:0] wd, input logic ab, input logic [31:0] ex);
    qa.push_back({ab, ex});
    i_mst.xfer(wr, ix, sb, wd);
  endtask : acc

  task automatic rd(input logic [15:0] ix, input logic [7:0] sb, input logic [31:0] ex);
    acc(1'b0, ix, sb, 32'h0, 1'b0, ex);
  endtask : rd

  task automatic rh(input logic [7:0] sb, input logic [31:0] ex);
    rd(ehs_pkg::IDX_ERR_HIST, sb, ex);
  endtask : rh

  // Remap order kept by the master; no PDO object lives here, so each step is refused
  task automatic remap();
    acc(1'b1, 16'h1800, 8'h01, 32'h8000_0000, 1'b1, 32'h0);
    acc(1'b1, 16'h1A00, 8'h00, 32'h0, 1'b1, 32'h0);
    acc(1'b1, 16'h1A00, 8'h01, 32'h6100_0110, 1'b1, 32'h0);
    acc(1'b1, 16'h1A00, 8'h00, 32'h1, 1'b1, 32'h0);
    acc(1'b1, 16'h1800, 8'h01, 32'h0, 1'b1, 32'h0);
  endtask : remap

  task automatic wait_q();
    for (int n = 0; n < 60 && qe.size() > 0; n++) @(posedge clk_sys);
    @(posedge clk_sys);
  endtask : wait_q

  task automatic cmp(input logic [32:0] got, input logic [32:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp

  task automatic chk_ack();
    cmp({od_abort_q, od_rdata_q}, (qa.size() > 0) ? qa.pop_front() : 33'h1FFFFFFFF);
  endtask : chk_ack

  task automatic chk_emcy();
    cmp({1'b0, emcy_word_q}, (qe.size() > 0) ? {1'b0, qe.pop_front()} : 33'h1FFFFFFFF);
  endtask : chk_emcy

  always @(negedge clk_sys) begin
    if (od_ack_q === 1'b1) chk_ack();
    if (emcy_strobe_q === 1'b1) chk_emcy();
  end

  task automatic stop_test();
    if (qa.size() != 0 || qe.size() != 0) errors++;
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : stop_test

  initial begin
    #500000;
    errors++;
    stop_test();
  end

  // ***************************************************************
  // Tests
  // ***************************************************************
  initial begin
    seed = 32'h00012E24;
    reset = 1'b1; ce = 1'b1; guard = 1'b0; hbm = 1'b0; ovr = 1'b0;
    hbn = 8'h00; errors = 0; check_count = 0;
    for (int k = 0; k < 7; k++) fk[k] = 8'h00;
    repeat (4) @(posedge clk_sys);
    reset <= 1'b0;
    rd(ehs_pkg::IDX_DEV_TYPE, 8'h00, {DTA, DTG});
    rd(ehs_pkg::IDX_ERR_REG, 8'h00, 32'h0);
    rh(8'h00, 32'h0);
    rd(ehs_pkg::IDX_MAKER_STAT, 8'h00, 32'h0);
    acc(1'b1, ehs_pkg::IDX_DEV_TYPE, 8'h00, 32'h1, 1'b1, 32'h0);
    acc(1'b0, ehs_pkg::IDX_ERR_REG, 8'h01, 32'h0, 1'b1, 32'h0);
    acc(1'b0, 16'h2000, 8'h00, 32'h0, 1'b1, 32'h0);
    acc(1'b0, ehs_pkg::IDX_ERR_HIST, 8'h12, 32'h0, 1'b1, 32'h0);
    acc(1'b1, ehs_pkg::IDX_ERR_HIST, 8'h00, 32'h5, 1'b1, 32'h0);
    remap();
    $display("test ident finished");
    hbn <= 8'(xs());
    for (int k = 0; k < 10; k++) begin
      c = int'(xs() % 8);
      w = wrd(k, c);
      qe.push_back(w);
      @(posedge clk_sys);
      set_src(k, c, 1'b1);
      wait_q();
      rh(8'h01, w);
      rh(8'h00, 32'h1);
      rd(ehs_pkg::IDX_ERR_REG, 8'h00, 32'h1);
      qe.push_back(32'h0);
      @(posedge clk_sys);
      set_src(k, c, 1'b0);
      wait_q();
      rh(8'h00, 32'h0);
      rd(ehs_pkg::IDX_ERR_REG, 8'h00, 32'h0);
    end
    $display("test kinds finished");
    for (int i = 0; i < 3; i++) begin
      qe.push_back(wrd(i == 2 ? 3 : i, i));
      @(posedge clk_sys);
      set_src(i == 2 ? 3 : i, i, 1'b1);
      wait_q();
    end
    rh(8'h01, wrd(3, 2));
    rh(8'h02, wrd(1, 1));
    rh(8'h03, wrd(0, 0));
    @(posedge clk_sys);
    set_src(1, 1, 1'b0);
    repeat (3) @(posedge clk_sys);
    rh(8'h01, wrd(3, 2));
    rh(8'h02, wrd(0, 0));
    rh(8'h03, 32'h0);
    rh(8'h00, 32'h2);
    acc(1'b1, ehs_pkg::IDX_ERR_HIST, 8'h00, 32'h0, 1'b0, 32'h0);
    rh(8'h00, 32'h0);
    rh(8'h01, 32'h0);
    rd(ehs_pkg::IDX_ERR_REG, 8'h00, 32'h1);
    // Last live condition gone: error reset code even though the list is empty
    qe.push_back(32'h0);
    @(posedge clk_sys);
    set_src(0, 0, 1'b0);
    set_src(3, 2, 1'b0);
    repeat (4) @(posedge clk_sys);
    rh(8'h00, 32'h0);
    rd(ehs_pkg::IDX_ERR_REG, 8'h00, 32'h0);
    $display("test order finished");
    // Eighteen rises at once: logged lowest source first, oldest falls off
    for (int i = 0; i < 18; i++) qe.push_back(wrd(i < 16 ? i % 2 : (i == 16 ? 7 : 9), i / 2));
    @(posedge clk_sys);
    fk[0] <= 8'hFF;
    fk[1] <= 8'hFF;
    guard <= 1'b1;
    ovr   <= 1'b1;
    wait_q();
    rh(8'h00, 32'h11);
    for (int s = 1; s < 18; s++) rh(8'(s), wrd(18 - s < 16 ? (18 - s) % 2 : (s == 2 ? 7 : 9), (18 - s) / 2));
    qe.push_back(32'h0);
    @(posedge clk_sys);
    fk[0] <= 8'h00;
    fk[1] <= 8'h00;
    guard <= 1'b0;
    ovr   <= 1'b0;
    repeat (30) @(posedge clk_sys);
    rh(8'h00, 32'h0);
    rd(ehs_pkg::IDX_ERR_REG, 8'h00, 32'h0);
    $display("test overflow finished");
    // Clock enable low must hold off logging; a mid-run reset relogs a held fault
    w = wrd(2, 4);
    @(posedge clk_sys);
    ce <= 1'b0;
    set_src(2, 4, 1'b1);
    repeat (5) @(posedge clk_sys);
    cmp({25'h0, err_reg_q}, 33'h0);
    qe.push_back(w);
    ce <= 1'b1;
    wait_q();
    rh(8'h01, w);
    // Let the read's answer be checked before reset wipes it
    repeat (2) @(posedge clk_sys);
    reset <= 1'b1;
    repeat (2) @(posedge clk_sys);
    qe.push_back(w);
    reset <= 1'b0;
    wait_q();
    rh(8'h00, 32'h1);
    qe.push_back(32'h0);
    @(posedge clk_sys);
    set_src(2, 4, 1'b0);
    wait_q();
    rh(8'h00, 32'h0);
    $display("test freeze finished");
    repeat (2) @(posedge clk_sys);
    stop_test();
  end
endmodule : ehs_core_tb
`default_nettype wire
